// file: rtl/orad_pkg.sv
// Package for the accumulator OR opcode decoder: byte encodings, forms and carriers.
// Assumes a byte-wide instruction stream on the core clock.
package orad_pkg;

    // Leading opcode bytes, then the second and third bytes of the 3Ch prefix sequence
    localparam logic [7:0] B1_PTR_IND = 8'h16;
    localparam logic [7:0] B1_DISP = 8'h06;
    localparam logic [7:0] B1_WIDE = 8'h0A;
    localparam logic [7:0] B1_REG_IDX = 8'h17;
    localparam logic [7:0] B1_PREFIX = 8'h3C;
    localparam logic [7:0] B2_PREFIX = 8'h07;
    localparam logic [7:0] B3_SDIR_WR = 8'hBE;

    // Second byte: upper nibble selects, lower nibble is fixed
    localparam int SEL_MSB = 7;
    localparam int SEL_LSB = 4;
    localparam logic [3:0] B2_LOW_NIB = 4'hE;
    localparam logic [3:0] SEL_SP_DISP = 4'h1;
    localparam logic [3:0] SEL_ABS16_RD = 4'h4;
    localparam logic [3:0] SEL_ABS24_RD = 4'h5;
    localparam logic [3:0] SEL_ABS16_WR = 4'hC;
    localparam logic [3:0] SEL_ABS24_WR = 4'hD;

    // Address lanes inside the assembled 24-bit operand
    localparam logic [1:0] LANE_LOW = 2'h0;
    localparam logic [1:0] LANE_HIGH = 2'h1;
    localparam logic [1:0] LANE_TOP = 2'h2;

    typedef enum logic [3:0] {
        ORAD_FORM_PTR_IND = 4'h0,
        ORAD_FORM_PTR_DISP = 4'h1,
        ORAD_FORM_SP_DISP = 4'h2,
        ORAD_FORM_BASE24_IDX = 4'h3,
        ORAD_FORM_ABS16_RD = 4'h4,
        ORAD_FORM_ABS24_RD = 4'h5,
        ORAD_FORM_ABS16_WR = 4'h6,
        ORAD_FORM_ABS24_WR = 4'h7,
        ORAD_FORM_SDIR_WR = 4'h8,
        ORAD_FORM_REG_IDX = 4'h9,
        ORAD_FORM_ILLEGAL = 4'hF
    } orad_form_t;

    typedef enum logic [2:0] {
        ORAD_PTR_NONE = 3'h0,
        ORAD_PTR_THIRD = 3'h1,
        ORAD_PTR_WORD = 3'h2,
        ORAD_PTR_FOURTH = 3'h3,
        ORAD_PTR_FIFTH = 3'h4,
        ORAD_PTR_SP = 3'h5
    } orad_ptr_t;

    typedef enum logic [2:0] {
        ORAD_IDX_NONE = 3'h0,
        ORAD_IDX_ACC = 3'h1,
        ORAD_IDX_B = 3'h2,
        ORAD_IDX_DE = 3'h3,
        ORAD_IDX_HL = 3'h4
    } orad_idx_t;

    typedef enum logic [1:0] {
        ORAD_UPD_NONE = 2'h0,
        ORAD_UPD_INC = 2'h1,
        ORAD_UPD_DEC = 2'h2
    } orad_upd_t;

    typedef struct packed {
        orad_form_t form;
        orad_ptr_t ptr;
        orad_idx_t idx;
        orad_upd_t upd;
        logic to_mem;
        logic [23:0] operand;
    } orad_dec_t;

    localparam orad_dec_t DEC_RESET = '{ORAD_FORM_ILLEGAL, ORAD_PTR_NONE, ORAD_IDX_NONE,
                                        ORAD_UPD_NONE, 1'b0, 24'h000000};

endpackage

// file: rtl/orad_decoder.sv
// Accumulator OR opcode decoder with a small OR result stage.
// Assumes the fetch unit and execution datapath run on mclk_i, so no synchronisers.
//
// Overview of operation
// - 16h then 0x/1x/2x/3x Eh: post-update pointer
// - 06h then pointer select, displacement third byte
// - 06h 1Eh: stack pointer plus displacement
// - 0Ah 4Eh: read 16-bit absolute, low first
// - 0Ah 5Eh: read 24-bit absolute, top first
// - 0Ah CEh: write 16-bit absolute, low first
// - 0Ah DEh: write 24-bit absolute, top first
// - 3Ch 07h BEh offset: OR through short pointer
// - 17h 0Eh/1Eh/2Eh: register plus register indexing
`timescale 1ns/100ps

module orad_decoder (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic fetch_valid_i,
    input wire logic [7:0] fetch_byte_i,
    output logic fetch_ready_o,
    output logic dec_valid_o,
    output orad_pkg::orad_dec_t dec_o,
    input wire logic dec_ready_i,
    input wire logic exec_go_i,
    input wire logic [7:0] exec_acc_i,
    input wire logic [7:0] exec_mem_i,
    output logic res_valid_o,
    output logic [7:0] res_data_o,
    output logic res_to_mem_o
);

    typedef enum logic [2:0] {
        ORAD_ST_B1 = 3'h0,
        ORAD_ST_B2 = 3'h1,
        ORAD_ST_PFX2 = 3'h2,
        ORAD_ST_PFX3 = 3'h3,
        ORAD_ST_OPND = 3'h4,
        ORAD_ST_OUT = 3'h5
    } orad_state_t;

    orad_state_t state_r;
    orad_state_t state_nxt;
    logic [7:0] first_r;
    logic [7:0] first_nxt;
    logic [1:0] left_r;
    logic [1:0] left_nxt;
    logic [1:0] pos_r;
    logic [1:0] pos_nxt;
    orad_pkg::orad_dec_t dec_r;
    orad_pkg::orad_dec_t dec_nxt;
    logic dst_mem_r;
    logic dst_mem_nxt;
    logic res_valid_r;
    logic res_valid_nxt;
    logic [7:0] res_data_r;
    logic [7:0] res_data_nxt;
    logic res_to_mem_r;
    logic res_to_mem_nxt;

    // Operand bytes that follow the opcode for each form
    function automatic logic [1:0] opnd_count(input orad_pkg::orad_form_t f);
        case (f)
            orad_pkg::ORAD_FORM_PTR_DISP,
            orad_pkg::ORAD_FORM_SP_DISP,
            orad_pkg::ORAD_FORM_SDIR_WR: opnd_count = 2'd1;
            orad_pkg::ORAD_FORM_ABS16_RD,
            orad_pkg::ORAD_FORM_ABS16_WR: opnd_count = 2'd2;
            orad_pkg::ORAD_FORM_ABS24_RD,
            orad_pkg::ORAD_FORM_ABS24_WR,
            orad_pkg::ORAD_FORM_BASE24_IDX: opnd_count = 2'd3;
            default: opnd_count = 2'd0;
        endcase
    endfunction

    // Which address lane the n-th operand byte fills
    function automatic logic [1:0] lane_of(input orad_pkg::orad_form_t f, input logic [1:0] n);
        if (f == orad_pkg::ORAD_FORM_ABS24_RD || f == orad_pkg::ORAD_FORM_ABS24_WR) begin
            // Uppermost byte leads, then low, then high
            if (n == 2'd0) begin
                lane_of = orad_pkg::LANE_TOP;
            end else if (n == 2'd1) begin
                lane_of = orad_pkg::LANE_LOW;
            end else begin
                lane_of = orad_pkg::LANE_HIGH;
            end
        end else begin
            // Low, high, then highest
            lane_of = n;
        end
    endfunction

    // Decode the second byte under a known first byte
    function automatic orad_pkg::orad_dec_t decode_b2(input logic [7:0] b1, input logic [7:0] b2);
        orad_pkg::orad_dec_t d;
        logic [3:0] sel;
        d = orad_pkg::DEC_RESET;
        sel = b2[orad_pkg::SEL_MSB:orad_pkg::SEL_LSB];
        if (b2[3:0] != orad_pkg::B2_LOW_NIB) begin
            d.form = orad_pkg::ORAD_FORM_ILLEGAL;
        end else if (b1 == orad_pkg::B1_PTR_IND) begin
            if (sel < 4'h8) begin
                d.form = orad_pkg::ORAD_FORM_PTR_IND;
                d.ptr = sel[0] ? orad_pkg::ORAD_PTR_WORD : orad_pkg::ORAD_PTR_THIRD;
                d.upd = sel[1] ? orad_pkg::ORAD_UPD_DEC : orad_pkg::ORAD_UPD_INC;
                if (sel[2]) begin
                    d.upd = orad_pkg::ORAD_UPD_NONE;
                    if (sel[1]) begin
                        d.ptr = sel[0] ? orad_pkg::ORAD_PTR_FIFTH : orad_pkg::ORAD_PTR_FOURTH;
                    end
                end
            end
        end else if (b1 == orad_pkg::B1_DISP) begin
            d.form = orad_pkg::ORAD_FORM_PTR_DISP;
            case (sel)
                4'h0: d.ptr = orad_pkg::ORAD_PTR_THIRD;
                4'h2: d.ptr = orad_pkg::ORAD_PTR_WORD;
                4'h3: d.ptr = orad_pkg::ORAD_PTR_FIFTH;
                4'h4: d.ptr = orad_pkg::ORAD_PTR_FOURTH;
                orad_pkg::SEL_SP_DISP: begin
                    d.form = orad_pkg::ORAD_FORM_SP_DISP;
                    d.ptr = orad_pkg::ORAD_PTR_SP;
                end
                default: d.form = orad_pkg::ORAD_FORM_ILLEGAL;
            endcase
        end else if (b1 == orad_pkg::B1_WIDE) begin
            case (sel)
                4'h0, 4'h1, 4'h2, 4'h3: begin
                    d.form = orad_pkg::ORAD_FORM_BASE24_IDX;
                    case (sel[1:0])
                        2'h0: d.idx = orad_pkg::ORAD_IDX_DE;
                        2'h1: d.idx = orad_pkg::ORAD_IDX_ACC;
                        2'h2: d.idx = orad_pkg::ORAD_IDX_HL;
                        default: d.idx = orad_pkg::ORAD_IDX_B;
                    endcase
                end
                orad_pkg::SEL_ABS16_RD: d.form = orad_pkg::ORAD_FORM_ABS16_RD;
                orad_pkg::SEL_ABS24_RD: d.form = orad_pkg::ORAD_FORM_ABS24_RD;
                orad_pkg::SEL_ABS16_WR: begin
                    d.form = orad_pkg::ORAD_FORM_ABS16_WR;
                    d.to_mem = 1'b1;
                end
                orad_pkg::SEL_ABS24_WR: begin
                    d.form = orad_pkg::ORAD_FORM_ABS24_WR;
                    d.to_mem = 1'b1;
                end
                default: d.form = orad_pkg::ORAD_FORM_ILLEGAL;
            endcase
        end else if (b1 == orad_pkg::B1_REG_IDX) begin
            d.form = orad_pkg::ORAD_FORM_REG_IDX;
            case (sel)
                4'h0: begin
                    d.ptr = orad_pkg::ORAD_PTR_THIRD;
                    d.idx = orad_pkg::ORAD_IDX_ACC;
                end
                4'h1: begin
                    d.ptr = orad_pkg::ORAD_PTR_WORD;
                    d.idx = orad_pkg::ORAD_IDX_ACC;
                end
                4'h2: begin
                    d.ptr = orad_pkg::ORAD_PTR_THIRD;
                    d.idx = orad_pkg::ORAD_IDX_B;
                end
                default: d.form = orad_pkg::ORAD_FORM_ILLEGAL;
            endcase
        end
        decode_b2 = d;
    endfunction

    // The stream stalls while a decoded instruction waits for the datapath
    assign fetch_ready_o = (state_r != ORAD_ST_OUT);
    assign dec_valid_o = (state_r == ORAD_ST_OUT);
    assign dec_o = dec_r;
    assign res_valid_o = res_valid_r;
    assign res_data_o = res_data_r;
    assign res_to_mem_o = res_to_mem_r;

    always_comb begin
        logic take;
        logic [1:0] lane;
        take = fetch_valid_i && fetch_ready_o;
        lane = lane_of(dec_r.form, pos_r);
        state_nxt = state_r;
        first_nxt = first_r;
        left_nxt = left_r;
        pos_nxt = pos_r;
        dec_nxt = dec_r;
        case (state_r)
            ORAD_ST_B1: begin
                if (take) begin
                    first_nxt = fetch_byte_i;
                    dec_nxt = orad_pkg::DEC_RESET;
                    if (fetch_byte_i == orad_pkg::B1_PREFIX) begin
                        state_nxt = ORAD_ST_PFX2;
                    end else if (fetch_byte_i == orad_pkg::B1_PTR_IND
                                 || fetch_byte_i == orad_pkg::B1_DISP
                                 || fetch_byte_i == orad_pkg::B1_WIDE
                                 || fetch_byte_i == orad_pkg::B1_REG_IDX) begin
                        state_nxt = ORAD_ST_B2;
                    end else begin
                        // Unknown leading byte is reported at once, nothing more is eaten
                        state_nxt = ORAD_ST_OUT;
                    end
                end
            end
            ORAD_ST_B2: begin
                if (take) begin
                    dec_nxt = decode_b2(first_r, fetch_byte_i);
                    pos_nxt = 2'd0;
                    left_nxt = opnd_count(dec_nxt.form);
                    if (opnd_count(dec_nxt.form) == 2'd0) begin
                        state_nxt = ORAD_ST_OUT;
                    end else begin
                        state_nxt = ORAD_ST_OPND;
                    end
                end
            end
            ORAD_ST_PFX2: begin
                if (take) begin
                    state_nxt = (fetch_byte_i == orad_pkg::B2_PREFIX) ? ORAD_ST_PFX3 : ORAD_ST_OUT;
                end
            end
            ORAD_ST_PFX3: begin
                if (take) begin
                    if (fetch_byte_i == orad_pkg::B3_SDIR_WR) begin
                        dec_nxt.form = orad_pkg::ORAD_FORM_SDIR_WR;
                        dec_nxt.to_mem = 1'b1;
                        pos_nxt = 2'd0;
                        left_nxt = 2'd1;
                        state_nxt = ORAD_ST_OPND;
                    end else begin
                        state_nxt = ORAD_ST_OUT;
                    end
                end
            end
            ORAD_ST_OPND: begin
                if (take) begin
                    case (lane)
                        orad_pkg::LANE_LOW: dec_nxt.operand[7:0] = fetch_byte_i;
                        orad_pkg::LANE_HIGH: dec_nxt.operand[15:8] = fetch_byte_i;
                        default: dec_nxt.operand[23:16] = fetch_byte_i;
                    endcase
                    pos_nxt = pos_r + 2'd1;
                    left_nxt = left_r - 2'd1;
                    if (left_r == 2'd1) begin
                        state_nxt = ORAD_ST_OUT;
                    end
                end
            end
            ORAD_ST_OUT: begin
                if (dec_ready_i) begin
                    state_nxt = ORAD_ST_B1;
                end
            end
            default: state_nxt = ORAD_ST_B1;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state_r <= ORAD_ST_B1;
            first_r <= 8'h00;
            left_r <= 2'h0;
            pos_r <= 2'h0;
            dec_r <= orad_pkg::DEC_RESET;
        end else begin
            state_r <= state_nxt;
            first_r <= first_nxt;
            left_r <= left_nxt;
            pos_r <= pos_nxt;
            dec_r <= dec_nxt;
        end
    end

    // Result stage: destination latched at hand-over so the decoder may move on
    always_comb begin
        dst_mem_nxt = dst_mem_r;
        if (dec_valid_o && dec_ready_i) begin
            dst_mem_nxt = dec_r.to_mem;
        end
        res_valid_nxt = exec_go_i;
        res_data_nxt = res_data_r;
        res_to_mem_nxt = res_to_mem_r;
        if (exec_go_i) begin
            res_data_nxt = exec_acc_i | exec_mem_i;
            res_to_mem_nxt = dst_mem_r;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            dst_mem_r <= 1'b0;
            res_valid_r <= 1'b0;
            res_data_r <= 8'h00;
            res_to_mem_r <= 1'b0;
        end else begin
            dst_mem_r <= dst_mem_nxt;
            res_valid_r <= res_valid_nxt;
            res_data_r <= res_data_nxt;
            res_to_mem_r <= res_to_mem_nxt;
        end
    end

endmodule

// file: verification/orad_decoder_properties.sv
// Checker for the accumulator OR decoder: fetch handshake, record shape and OR stage.
// Assumes it is bound to orad_decoder and sees only that module's ports.
`timescale 1ns/100ps

module orad_decoder_properties (
    input wire logic mclk_i,
    input wire logic reset_i,
    input wire logic fetch_valid_i,
    input wire logic [7:0] fetch_byte_i,
    input wire logic fetch_ready_o,
    input wire logic dec_valid_o,
    input wire orad_pkg::orad_dec_t dec_o,
    input wire logic dec_ready_i,
    input wire logic exec_go_i,
    input wire logic [7:0] exec_acc_i,
    input wire logic [7:0] exec_mem_i,
    input wire logic res_valid_o,
    input wire logic [7:0] res_data_o,
    input wire logic res_to_mem_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);

    property p_busy;
        dec_valid_o |-> !fetch_ready_o;
    endproperty
    a_busy: assert property (p_busy) else $error("fetch ready while record pending");

    property p_hold;
        dec_valid_o && !dec_ready_i |=> dec_valid_o && $stable(dec_o);
    endproperty
    a_hold: assert property (p_hold) else $error("record changed before accept");

    property p_release;
        dec_valid_o && dec_ready_i |=> !dec_valid_o && fetch_ready_o;
    endproperty
    a_release: assert property (p_release) else $error("record not released");

    property p_or;
        exec_go_i |=> res_valid_o && res_data_o == ($past(exec_acc_i) | $past(exec_mem_i));
    endproperty
    a_or: assert property (p_or) else $error("OR result wrong or late");

    property p_pulse;
        !exec_go_i |=> !res_valid_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("result valid without go");

    property p_abs16;
        dec_valid_o && dec_o.form == orad_pkg::ORAD_FORM_ABS16_RD
            |-> !dec_o.to_mem && dec_o.operand[23:16] == 8'h00;
    endproperty
    a_abs16: assert property (p_abs16) else $error("16-bit read record malformed");

    property p_wr;
        dec_valid_o && dec_o.form inside {orad_pkg::ORAD_FORM_ABS16_WR,
            orad_pkg::ORAD_FORM_ABS24_WR} |-> dec_o.to_mem;
    endproperty
    a_wr: assert property (p_wr) else $error("absolute write not to memory");

    property p_sdir;
        dec_valid_o && dec_o.form == orad_pkg::ORAD_FORM_SDIR_WR
            |-> dec_o.to_mem && dec_o.operand[23:8] == 16'h0000;
    endproperty
    a_sdir: assert property (p_sdir) else $error("short pointer record malformed");

    property p_sp;
        dec_valid_o && dec_o.form == orad_pkg::ORAD_FORM_SP_DISP
            |-> dec_o.ptr == orad_pkg::ORAD_PTR_SP;
    endproperty
    a_sp: assert property (p_sp) else $error("stack form without stack pointer");

    c_wr24: cover property (dec_valid_o && dec_o.form == orad_pkg::ORAD_FORM_ABS24_WR);
    c_sdir: cover property (dec_valid_o && dec_o.form == orad_pkg::ORAD_FORM_SDIR_WR);
    c_res: cover property (res_valid_o && res_to_mem_o);
endmodule

bind orad_decoder orad_decoder_properties u_props (.mclk_i(mclk_i), .reset_i(reset_i),
    .fetch_valid_i(fetch_valid_i), .fetch_byte_i(fetch_byte_i), .fetch_ready_o(fetch_ready_o),
    .dec_valid_o(dec_valid_o), .dec_o(dec_o), .dec_ready_i(dec_ready_i), .exec_go_i(exec_go_i),
    .exec_acc_i(exec_acc_i), .exec_mem_i(exec_mem_i), .res_valid_o(res_valid_o),
    .res_data_o(res_data_o), .res_to_mem_o(res_to_mem_o));

// file: verification/orad_fetch_model.sv
// Fetch unit model: offers instruction bytes one at a time to the decoder.
// Assumes its tasks are called just after a rising edge of mclk_i.
`timescale 1ns/100ps

module orad_fetch_model (
    input wire logic mclk_i,
    input wire logic fetch_ready_i,
    output logic fetch_valid_o,
    output logic [7:0] fetch_byte_o
);
    logic ready_seen_r;

    initial begin
        fetch_valid_o = 1'b0;
        fetch_byte_o = 8'hA5;
    end

    // Ready as the edge saw it, free of the race with the decoder's update
    always @(posedge mclk_i) begin
        ready_seen_r <= fetch_ready_i;
    end

    task automatic offer(input logic [7:0] b);
        fetch_valid_o = 1'b1;
        fetch_byte_o = b;
    endtask

    // Holds the byte until an edge takes it
    task automatic send_byte(input logic [7:0] b);
        offer(b);
        do begin
            @(posedge mclk_i);
            #1;
        end while (ready_seen_r !== 1'b1);
    endtask

    // Released line shows the inverse so a stale byte cannot pass as fresh
    task automatic idle();
        fetch_valid_o = 1'b0;
        fetch_byte_o = ~fetch_byte_o;
    endtask
endmodule

// file: verification/orad_decoder_bench.sv
// Bench for the accumulator OR decoder: every form, bad bytes and the OR stage.
// Assumes orad_fetch_model on the fetch port and the checker bound to the decoder.
`timescale 1ns/100ps

module orad_decoder_bench;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic fetch_valid_i;
    logic [7:0] fetch_byte_i;
    logic fetch_ready_o;
    logic dec_valid_o;
    orad_pkg::orad_dec_t dec_o;
    orad_pkg::orad_dec_t e;
    logic dec_ready_i = 1'b0;
    logic exec_go_i = 1'b0;
    logic [7:0] exec_acc_i = 8'h00;
    logic [7:0] exec_mem_i = 8'h00;
    logic res_valid_o;
    logic [7:0] res_data_o;
    logic res_to_mem_o;
    int num_errors = 0;
    int checked = 0;
    int cycles = 0;

    orad_decoder dut (.mclk_i(mclk_i), .reset_i(reset_i), .fetch_valid_i(fetch_valid_i),
        .fetch_byte_i(fetch_byte_i), .fetch_ready_o(fetch_ready_o), .dec_valid_o(dec_valid_o),
        .dec_o(dec_o), .dec_ready_i(dec_ready_i), .exec_go_i(exec_go_i),
        .exec_acc_i(exec_acc_i), .exec_mem_i(exec_mem_i), .res_valid_o(res_valid_o),
        .res_data_o(res_data_o), .res_to_mem_o(res_to_mem_o));
    orad_fetch_model fetch (.mclk_i(mclk_i), .fetch_ready_i(fetch_ready_o),
        .fetch_valid_o(fetch_valid_i), .fetch_byte_o(fetch_byte_i));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end

    task automatic complete_run();
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The whole run needs well under a thousand cycles
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
        checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask

    // One stall cycle first, so the record must stand while the datapath waits
    task automatic accept();
        @(posedge mclk_i);
        #1;
        chk("dec_valid_o held", 37'h1, 37'(dec_valid_o));
        chk("fetch_ready_o stalled", 37'h0, 37'(fetch_ready_o));
        dec_ready_i = 1'b1;
        @(posedge mclk_i);
        #1;
        dec_ready_i = 1'b0;
        chk("fetch_ready_o released", 37'h1, 37'(fetch_ready_o));
    endtask

    // Sends n bytes back to back, first byte in the top lane of b
    task automatic run(input logic [39:0] b, input int n);
        for (int k = 0; k < n; k++) begin
            fetch.send_byte(b[39 - 8 * k -: 8]);
        end
        fetch.idle();
        chk("dec_valid_o", 37'h1, 37'(dec_valid_o));
        chk("dec_o", e, dec_o);
        accept();
    endtask

    task automatic t_ptr();
        orad_pkg::orad_ptr_t p[8];
        p = '{orad_pkg::ORAD_PTR_THIRD, orad_pkg::ORAD_PTR_WORD, orad_pkg::ORAD_PTR_THIRD,
            orad_pkg::ORAD_PTR_WORD, orad_pkg::ORAD_PTR_THIRD, orad_pkg::ORAD_PTR_WORD,
            orad_pkg::ORAD_PTR_FOURTH, orad_pkg::ORAD_PTR_FIFTH};
        for (int k = 0; k < 8; k++) begin
            e = orad_pkg::DEC_RESET;
            e.form = orad_pkg::ORAD_FORM_PTR_IND;
            e.ptr = p[k];
            if (k < 2) e.upd = orad_pkg::ORAD_UPD_INC;
            else if (k < 4) e.upd = orad_pkg::ORAD_UPD_DEC;
            run({8'h16, 4'(k), 4'hE, 24'h0}, 2);
        end
    endtask

    task automatic t_disp();
        orad_pkg::orad_ptr_t p[5];
        int s[5];
        p = '{orad_pkg::ORAD_PTR_THIRD, orad_pkg::ORAD_PTR_WORD, orad_pkg::ORAD_PTR_FIFTH,
            orad_pkg::ORAD_PTR_FOURTH, orad_pkg::ORAD_PTR_SP};
        s = '{0, 2, 3, 4, 1};
        for (int k = 0; k < 5; k++) begin
            e = orad_pkg::DEC_RESET;
            e.form = k == 4 ? orad_pkg::ORAD_FORM_SP_DISP : orad_pkg::ORAD_FORM_PTR_DISP;
            e.ptr = p[k];
            e.operand = {16'h0, 8'hF8 | 8'(k)};
            run({8'h06, 4'(s[k]), 4'hE, 8'hF8 | 8'(k), 16'h0}, 3);
        end
    endtask

    task automatic t_imm();
        orad_pkg::orad_idx_t x[4];
        x = '{orad_pkg::ORAD_IDX_DE, orad_pkg::ORAD_IDX_ACC, orad_pkg::ORAD_IDX_HL,
            orad_pkg::ORAD_IDX_B};
        for (int k = 0; k < 4; k++) begin
            e = orad_pkg::DEC_RESET;
            e.form = orad_pkg::ORAD_FORM_BASE24_IDX;
            e.idx = x[k];
            e.operand = {8'hC0 | 8'(k), 16'h2211};
            run({8'h0A, 4'(k), 4'hE, 8'h11, 8'h22, 8'hC0 | 8'(k)}, 5);
        end
    endtask

    task automatic t_abs();
        e = orad_pkg::DEC_RESET;
        e.form = orad_pkg::ORAD_FORM_ABS16_RD;
        e.operand = 24'h001234;
        run({8'h0A, 8'h4E, 8'h34, 8'h12, 8'h00}, 4);
        e.form = orad_pkg::ORAD_FORM_ABS24_RD;
        e.operand = 24'h561234;
        run({8'h0A, 8'h5E, 8'h56, 8'h34, 8'h12}, 5);
        e.form = orad_pkg::ORAD_FORM_ABS16_WR;
        e.to_mem = 1'b1;
        e.operand = 24'h00BEEF;
        run({8'h0A, 8'hCE, 8'hEF, 8'hBE, 8'h00}, 4);
        e.form = orad_pkg::ORAD_FORM_ABS24_WR;
        e.operand = 24'hA1B2C3;
        run({8'h0A, 8'hDE, 8'hA1, 8'hC3, 8'hB2}, 5);
    endtask

    task automatic t_sdir();
        e = orad_pkg::DEC_RESET;
        e.form = orad_pkg::ORAD_FORM_SDIR_WR;
        e.to_mem = 1'b1;
        e.operand = 24'h00009A;
        run({8'h3C, 8'h07, 8'hBE, 8'h9A, 8'h00}, 4);
    endtask

    task automatic t_reg();
        orad_pkg::orad_ptr_t p[3];
        orad_pkg::orad_idx_t x[3];
        p = '{orad_pkg::ORAD_PTR_THIRD, orad_pkg::ORAD_PTR_WORD, orad_pkg::ORAD_PTR_THIRD};
        x = '{orad_pkg::ORAD_IDX_ACC, orad_pkg::ORAD_IDX_ACC, orad_pkg::ORAD_IDX_B};
        for (int k = 0; k < 3; k++) begin
            e = orad_pkg::DEC_RESET;
            e.form = orad_pkg::ORAD_FORM_REG_IDX;
            e.ptr = p[k];
            e.idx = x[k];
            run({8'h17, 4'(k), 4'hE, 24'h0}, 2);
        end
    endtask

    // A bad byte may or may not be eaten, so it is offered but not waited on
    task automatic t_bad(input logic [7:0] b1, input logic [7:0] b2);
        fetch.send_byte(b1);
        fetch.offer(b2);
        for (int k = 0; k < 4 && dec_valid_o !== 1'b1; k++) begin
            @(posedge mclk_i);
            #1;
        end
        chk("dec_o.form", 37'(orad_pkg::ORAD_FORM_ILLEGAL), 37'(dec_o.form));
        fetch.idle();
        accept();
    endtask

    task automatic t_exec(input logic [7:0] a, input logic [7:0] m, input logic tm);
        exec_go_i = 1'b1;
        exec_acc_i = a;
        exec_mem_i = m;
        @(posedge mclk_i);
        #1;
        exec_go_i = 1'b0;
        exec_acc_i = ~a;
        chk("res_valid_o", 37'h1, 37'(res_valid_o));
        chk("res_data_o", 37'(a | m), 37'(res_data_o));
        chk("res_to_mem_o", 37'(tm), 37'(res_to_mem_o));
    endtask

    // Reset in the middle of an operand fetch must drop the half-built record
    task automatic t_reset();
        fetch.send_byte(8'h0A);
        fetch.send_byte(8'h4E);
        fetch.idle();
        reset_i = 1'b1;
        @(posedge mclk_i);
        #1;
        reset_i = 1'b0;
        chk("fetch_ready_o", 37'h1, 37'(fetch_ready_o));
        chk("dec_valid_o", 37'h0, 37'(dec_valid_o));
        chk("dec_o", orad_pkg::DEC_RESET, dec_o);
        chk("res_data_o", 37'h0, 37'(res_data_o));
    endtask

    initial begin
        repeat (4) @(posedge mclk_i);
        #1;
        chk("dec_o", orad_pkg::DEC_RESET, dec_o);
        chk("fetch_ready_o", 37'h1, 37'(fetch_ready_o));
        reset_i = 1'b0;
        t_ptr();
        t_disp();
        t_imm();
        t_abs();
        t_exec(8'h0F, 8'hA0, 1'b1);
        t_sdir();
        t_reg();
        t_exec(8'h55, 8'h0A, 1'b0);
        t_reset();
        t_bad(8'h06, 8'h5E);
        t_bad(8'h17, 8'h3E);
        t_bad(8'h16, 8'h0F);
        t_bad(8'h3C, 8'h08);
        complete_run();
    end
endmodule
